// ==== core/ebu_core.sv ====
// external bus unit: access sequencer, pin drivers and hold arbitration
// assumes the cpu holds req_in and its operands until ack_out pulses
`timescale 1ns/1ps
`default_nettype none
module ebu_core
  import ebu_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [EBU_AW-1:0] addr_in,
  input wire logic [EBU_DW-1:0] wdata_in,
  output logic ack_out,
  output logic [EBU_DW-1:0] rdata_out,
  output logic busy_out,
  input wire logic single_chip_in,
  input wire logic [1:0] addr_space_in,
  input wire logic select_timing_config_bit_in,
  input wire logic arbitration_enable_bit_in,
  input wire logic arbitration_pin_direction_bit_in,
  input wire logic [EBU_NWIN-1:0][15:0] window_address_select_reg_in,
  input wire logic [EBU_NWIN-1:0][15:0] window_bus_config_reg_in,
  input wire logic [15:0] default_bus_config_reg_in,
  input wire logic [EBU_DW-1:0] shared_bus_port_in,
  output logic [EBU_DW-1:0] shared_bus_port_out,
  output logic [1:0] shared_bus_port_oe_out,
  output logic [15:0] dedicated_address_port_out,
  output logic [7:0] seg_addr_out,
  output logic ale_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic [EBU_NCS-1:0] cs_n_out,
  output logic ctrl_oe_out,
  input wire logic ready_in,
  input wire logic hold_n_in,
  input wire logic bus_release_grant_n_in,
  output logic bus_release_grant_n_out,
  output logic bus_release_grant_oe_out,
  output logic bus_want_back_request_n_out,
  output logic bus_want_back_request_oe_out
);
  ebu_state_t state_reg, state_next;
  logic [EBU_AW-1:0] addr_reg, in_addr;
  logic [EBU_DW-1:0] wdata_reg;
  logic we_reg, ale_long_reg, cs_late_reg, wait_done, bus_lost, start_acc, slave;
  logic [15:0] cfg_reg, dec_cfg, cur_cfg;
  logic [2:0] win_reg, dec_win;
  logic [7:0] seg_mask;
  logic next_acc, next_strobe;

  assign seg_mask = ebu_seg_mask(addr_space_in);
  // upper lines outside the chosen space never reach the decoder
  assign in_addr = {addr_in[23:16] & seg_mask, addr_in[15:0]};
  assign slave = arbitration_pin_direction_bit_in;
  // master loses the bus to a hold request, slave owns it only when granted
  assign bus_lost = arbitration_enable_bit_in &&
    (slave ? bus_release_grant_n_in : !hold_n_in);
  assign start_acc = (state_reg == ST_IDLE) && (state_next == ST_ADDR);
  assign cur_cfg = (state_reg == ST_IDLE) ? dec_cfg : cfg_reg;
  assign next_acc = (state_next != ST_IDLE) && (state_next != ST_HOLD);
  assign next_strobe = (state_next == ST_DATA);
  assign busy_out = (state_reg != ST_IDLE);

  ebu_window_decode u_decode (
    .addr_in(in_addr),
    .window_address_select_reg_in(window_address_select_reg_in),
    .window_bus_config_reg_in(window_bus_config_reg_in),
    .default_bus_config_reg_in(default_bus_config_reg_in),
    .win_idx_out(dec_win),
    .cfg_out(dec_cfg)
  );

  ebu_wait_timer u_wait (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .start_in((state_next == ST_DATA) && (state_reg != ST_DATA)),
    .wait_in(cur_cfg[BC_WAIT_LSB +: BC_WAIT_W]),
    .rdy_en_in(cfg_reg[BC_RDYEN]),
    .rdy_pol_in(cfg_reg[BC_WAIT_POLARITY_BIT]),
    .ready_in(ready_in),
    .done_out(wait_done)
  );

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        // a pending hold is served before a new cpu access
        if (bus_lost) begin
          state_next = ST_HOLD;
        end else if (req_in && !single_chip_in) begin
          state_next = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (!ale_long_reg) begin
          state_next = cfg_reg[BC_RWD] ? ST_RWDLY : ST_DATA;
        end
      end
      ST_RWDLY: state_next = ST_DATA;
      ST_DATA: begin
        if (wait_done) begin
          state_next = cfg_reg[BC_TRI] ? ST_TRI : ST_IDLE;
        end
      end
      ST_TRI: state_next = ST_IDLE;
      ST_HOLD: begin
        if (!bus_lost) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  // access operands latched once so the cpu side may change mid-cycle
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      addr_reg <= '0;
      wdata_reg <= PORT_RESET;
      we_reg <= 1'b0;
      cfg_reg <= 16'h0000;
      win_reg <= WIN_DEFAULT;
    end else if (ce_in && start_acc) begin
      addr_reg <= in_addr;
      wdata_reg <= wdata_in;
      we_reg <= we_in;
      cfg_reg <= dec_cfg;
      win_reg <= dec_win;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ale_long_reg <= 1'b0;
      ale_out <= 1'b0;
    end else if (ce_in) begin
      ale_long_reg <= start_acc && dec_cfg[BC_ALEW];
      ale_out <= (state_next == ST_ADDR);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_n_out <= 1'b1;
      wr_n_out <= 1'b1;
      ctrl_oe_out <= 1'b1;
    end else if (ce_in) begin
      rd_n_out <= !(next_strobe && !we_reg);
      wr_n_out <= !(next_strobe && we_reg);
      ctrl_oe_out <= (state_next != ST_HOLD);
    end
  end

  // one clock stands in for the half-cycle select delay
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cs_n_out <= CS_IDLE;
      cs_late_reg <= 1'b0;
    end else if (ce_in) begin
      cs_late_reg <= start_acc && !select_timing_config_bit_in;
      if (!next_acc) begin
        cs_n_out <= CS_IDLE;
      end else if (start_acc && select_timing_config_bit_in) begin
        cs_n_out <= ~ebu_cs_onehot(dec_win);
      end else if (cs_late_reg) begin
        cs_n_out <= ~ebu_cs_onehot(win_reg);
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      shared_bus_port_out <= PORT_RESET;
      shared_bus_port_oe_out <= 2'b00;
    end else if (ce_in) begin
      shared_bus_port_oe_out <= 2'b00;
      if (state_next == ST_ADDR && cur_cfg[BC_MUX]) begin
        shared_bus_port_out <= start_acc ? in_addr[15:0] : addr_reg[15:0];
        shared_bus_port_oe_out <= 2'b11;
      end else if ((next_strobe || state_next == ST_RWDLY) && we_reg) begin
        shared_bus_port_out <= wdata_reg;
        // byte-wide devices only see the low lane
        shared_bus_port_oe_out <= cfg_reg[BC_BYTE] ? 2'b01 : 2'b11;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      dedicated_address_port_out <= PORT_RESET;
      seg_addr_out <= 8'h00;
    end else if (ce_in && start_acc) begin
      if (!dec_cfg[BC_MUX]) begin
        dedicated_address_port_out <= in_addr[15:0];
      end
      seg_addr_out <= in_addr[23:16];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ack_out <= 1'b0;
      rdata_out <= PORT_RESET;
    end else if (ce_in) begin
      ack_out <= (state_reg == ST_DATA) && wait_done;
      if ((state_reg == ST_DATA) && wait_done && !we_reg) begin
        rdata_out <= cfg_reg[BC_BYTE] ?
          {8'h00, shared_bus_port_in[7:0]} : shared_bus_port_in;
      end
    end
  end

  // grant pin is driven only by a master; a slave reads it instead
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      bus_release_grant_n_out <= 1'b1;
      bus_release_grant_oe_out <= 1'b0;
      bus_want_back_request_n_out <= 1'b1;
      bus_want_back_request_oe_out <= 1'b0;
    end else if (ce_in) begin
      bus_release_grant_n_out <= !(state_next == ST_HOLD && !slave);
      bus_release_grant_oe_out <= arbitration_enable_bit_in && !slave;
      bus_want_back_request_n_out <= !(state_next == ST_HOLD && req_in);
      bus_want_back_request_oe_out <= arbitration_enable_bit_in;
    end
  end

  sequence s_start_late;
    ce_in && start_acc && !select_timing_config_bit_in;
  endsequence
  sequence s_late_select;
    (ale_out && cs_n_out == CS_IDLE) ##1 (cs_n_out != CS_IDLE);
  endsequence

  property p_single_chip;
    @(posedge sys_clk_in) disable iff (rst_in)
      (state_reg == ST_IDLE && single_chip_in) |=> !ale_out;
  endproperty
  a_single_chip: assert property (p_single_chip) else $error("access in single chip");
  property p_demux_addr;
    @(posedge sys_clk_in) disable iff (rst_in)
      (state_reg == ST_DATA && !cfg_reg[BC_MUX]) |->
        dedicated_address_port_out == addr_reg[15:0];
  endproperty
  a_demux_addr: assert property (p_demux_addr) else $error("demux address wrong");
  property p_byte_lane;
    @(posedge sys_clk_in) disable iff (rst_in)
      (state_reg == ST_DATA && cfg_reg[BC_BYTE]) |-> !shared_bus_port_oe_out[1];
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("upper lane driven");
  property p_mux_addr;
    @(posedge sys_clk_in) disable iff (rst_in)
      (state_reg == ST_ADDR && cfg_reg[BC_MUX]) |->
        shared_bus_port_oe_out == 2'b11 && shared_bus_port_out == addr_reg[15:0];
  endproperty
  a_mux_addr: assert property (p_mux_addr) else $error("mux address missing");
  property p_waits;
    @(posedge sys_clk_in) disable iff (rst_in || !ce_in)
      ($rose(state_reg == ST_DATA) && cfg_reg[BC_WAIT_LSB +: 2] == 2'h2) |->
        (state_reg == ST_DATA && !ack_out) [*3];
  endproperty
  a_waits: assert property (p_waits) else $error("wait states cut short");
  property p_one_select;
    @(posedge sys_clk_in) disable iff (rst_in)
      $onehot0(~cs_n_out) && (cs_n_out == CS_IDLE || ~cs_n_out == ebu_cs_onehot(win_reg));
  endproperty
  a_one_select: assert property (p_one_select) else $error("wrong select");
  property p_cs_late;
    @(posedge sys_clk_in) disable iff (rst_in || !ce_in)
      s_start_late |=> s_late_select;
  endproperty
  a_cs_late: assert property (p_cs_late) else $error("select not delayed");
  property p_cs_early;
    @(posedge sys_clk_in) disable iff (rst_in || !ce_in)
      (start_acc && select_timing_config_bit_in) |=> ale_out && cs_n_out != CS_IDLE;
  endproperty
  a_cs_early: assert property (p_cs_early) else $error("select not with latch");
  property p_ready;
    @(posedge sys_clk_in) disable iff (rst_in)
      $rose(ack_out) && cfg_reg[BC_RDYEN] |-> $past(ready_in) == cfg_reg[BC_WAIT_POLARITY_BIT];
  endproperty
  a_ready: assert property (p_ready) else $error("ended without ready");
  property p_seg;
    @(posedge sys_clk_in) disable iff (rst_in)
      ale_out |-> (seg_addr_out & ~seg_mask) == 8'h00;
  endproperty
  a_seg: assert property (p_seg) else $error("segment line outside space");
  property p_hold;
    @(posedge sys_clk_in) disable iff (rst_in || !ce_in)
      (state_reg == ST_IDLE && bus_lost && !slave) |=>
        !ctrl_oe_out && !bus_release_grant_n_out;
  endproperty
  a_hold: assert property (p_hold) else $error("hold not granted");
  property p_slave_grant;
    @(posedge sys_clk_in) disable iff (rst_in || !ce_in)
      slave |=> !bus_release_grant_oe_out;
  endproperty
  a_slave_grant: assert property (p_slave_grant) else $error("slave drives grant");
endmodule : ebu_core
`default_nettype wire

// ==== core/ebu_pkg.sv ====
// constants, types and decoders shared by the external bus unit
// assumes one 200 MHz clock; all control bits arrive as plain ports
// What this block does
// - single-chip plus four mux/demux, 8/16-bit modes
// - demux: address on dedicated port, data shared
// - mux: address and data both on shared port
// - cycle, tristate, latch strobe, strobe delay programmable
// - four windows, each select plus bus config
// - window 4 beats 3, window 2 beats 1
// - unmatched accesses use default bus config
// - five active-low selects, four windows plus default
// - ready input stretches bus cycles
// - arbitration enable hands pins to the unit
// - master after reset; direction bit selects slave
// - address space limited to 1M/256K/64K or 16M
// - segment lines eight, four, two or none
// - default: selects change half cycle after latch (here one clock after)
// - timing bit: selects change with latch strobe
// - ready level taken from window polarity bit
package ebu_pkg;
  localparam int EBU_AW = 24;
  localparam int EBU_DW = 16;
  localparam int EBU_NWIN = 4;
  localparam int EBU_NCS = 5;
  // bus configuration fields
  localparam int BC_WAIT_LSB = 0;
  localparam int BC_WAIT_W = 4;
  localparam int BC_TRI = 4;
  localparam int BC_ALEW = 5;
  localparam int BC_RWD = 6;
  localparam int BC_MUX = 7;
  localparam int BC_BYTE = 8;
  localparam int BC_RDYEN = 9;
  localparam int BC_WAIT_POLARITY_BIT = 10;
  localparam int BC_WINEN = 11;
  // address select fields: base a[23:12] and range code
  localparam int AS_BASE_LSB = 4;
  localparam int AS_RANGE_W = 4;
  localparam int AS_PAGE_LSB = 12;
  // address space codes and the default window index
  localparam logic [1:0] SPACE_16M = 2'h0;
  localparam logic [1:0] SPACE_1M = 2'h1;
  localparam logic [1:0] SPACE_256K = 2'h2;
  localparam logic [1:0] SPACE_64K = 2'h3;
  localparam logic [2:0] WIN_DEFAULT = 3'h0;
  // reset values of outputs and the wait counter
  localparam logic [4:0] CS_IDLE = 5'h1f;
  localparam logic [15:0] PORT_RESET = 16'h0000;
  localparam logic [3:0] WAIT_ZERO = 4'h0;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_RWDLY = 6'h04,
    ST_DATA = 6'h08,
    ST_TRI = 6'h10,
    ST_HOLD = 6'h20
  } ebu_state_t;

  function automatic logic [7:0] ebu_seg_mask(input logic [1:0] space);
    unique case (space)
      SPACE_16M: ebu_seg_mask = 8'hff;
      SPACE_1M: ebu_seg_mask = 8'h0f;
      SPACE_256K: ebu_seg_mask = 8'h03;
      SPACE_64K: ebu_seg_mask = 8'h00;
    endcase
  endfunction : ebu_seg_mask

  function automatic logic [4:0] ebu_cs_onehot(input logic [2:0] idx);
    ebu_cs_onehot = 5'h01 << idx;
  endfunction : ebu_cs_onehot
endpackage : ebu_pkg

// ==== core/ebu_wait_timer.sv ====
// counts programmed wait states, then waits for the ready level
// assumes ready_in is synchronous to sys_clk_in
`timescale 1ns/1ps
`default_nettype none
module ebu_wait_timer
  import ebu_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic [BC_WAIT_W-1:0] wait_in,
  input wire logic rdy_en_in,
  input wire logic rdy_pol_in,
  input wire logic ready_in,
  output logic done_out
);
  logic [BC_WAIT_W-1:0] cnt_reg;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cnt_reg <= WAIT_ZERO;
    end else if (ce_in) begin
      if (start_in) begin
        cnt_reg <= wait_in;
      end else if (cnt_reg != WAIT_ZERO) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end

  // ready only matters once the fixed wait states have run out
  assign done_out = ce_in && !start_in && (cnt_reg == WAIT_ZERO) &&
    (!rdy_en_in || (ready_in == rdy_pol_in));
endmodule : ebu_wait_timer
`default_nettype wire

// ==== core/ebu_window_decode.sv ====
// resolves an access address to a window index and its bus configuration
// assumes the address is already cut to the selected address space
`timescale 1ns/1ps
`default_nettype none
module ebu_window_decode
  import ebu_pkg::*;
(
  input wire logic [EBU_AW-1:0] addr_in,
  input wire logic [EBU_NWIN-1:0][15:0] window_address_select_reg_in,
  input wire logic [EBU_NWIN-1:0][15:0] window_bus_config_reg_in,
  input wire logic [15:0] default_bus_config_reg_in,
  output logic [2:0] win_idx_out,
  output logic [15:0] cfg_out
);
  logic [EBU_NWIN-1:0] hit;

  for (genvar w = 0; w < EBU_NWIN; w++) begin : g_hit
    logic [11:0] page_mask;
    logic [3:0] range;
    assign range = window_address_select_reg_in[w][AS_RANGE_W-1:0];
    // ranges beyond the page field match every address, whatever the base
    assign page_mask = (range > 4'hb) ? 12'h000 : (12'hfff << range);
    assign hit[w] = window_bus_config_reg_in[w][BC_WINEN] &&
      (((addr_in[EBU_AW-1:AS_PAGE_LSB] ^
         window_address_select_reg_in[w][15:AS_BASE_LSB]) & page_mask) == 12'h000);
  end

  // highest window wins: 4 over 3 and 2 over 1
  always_comb begin
    win_idx_out = WIN_DEFAULT;
    cfg_out = default_bus_config_reg_in;
    for (int w = 0; w < EBU_NWIN; w++) begin
      if (hit[w]) begin
        win_idx_out = 3'(w + 1);
        cfg_out = window_bus_config_reg_in[w];
      end
    end
  end
endmodule : ebu_window_decode
`default_nettype wire

// ==== verification/ebu_core_tb.sv ====
// self-checking bench for the external bus unit, one task per scenario
// assumes ebu_mem_model on the pins; inputs change on falling clock edges
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ebu_core_tb;
  import ebu_pkg::*;
  localparam logic [7:0] F_EN = 8'h80, F_POL = 8'h40, F_RE = 8'h20, F_B8 = 8'h10;
  localparam logic [7:0] F_MUX = 8'h08, F_RWD = 8'h04, F_ALE = 8'h02, F_TRI = 8'h01;
  logic sys_clk_in = 1'b0, rst_in = 1'b1, req_in = 1'b0, we_in = 1'b0;
  logic [23:0] addr_in = 24'h000000;
  logic [15:0] wdata_in = 16'h0000, dbcr = 16'h0000;
  logic single_chip_in = 1'b0, select_timing_config_bit = 1'b0, arb_en = 1'b0, arb_dir = 1'b0;
  logic [1:0] addr_space_in = 2'h0;
  logic [EBU_NWIN-1:0][15:0] wasr = '0, wbcr = '0;
  logic hold_n_in = 1'b1, grant_drv = 1'b0, rdy_pol = 1'b1, ce_en = 1'b1, ack_busy = 1'b0;
  logic [3:0] rdy_dly = 4'h0;
  wire logic ack_out, busy_out, ale_out, rd_n_out, wr_n_out, ctrl_oe_out, ready_w, grant_w;
  wire logic [15:0] rdata_out, port_out, pins, mdl, ded_out;
  wire logic [1:0] port_oe;
  wire logic [7:0] seg_out;
  wire logic [4:0] cs_n_out;
  wire logic grant_n_out, grant_oe, bus_want_back_request_n, bus_want_back_request_oe;
  int fails = 0, checks_done = 0, cyc = 0, n = 0;
  logic [4:0] cs_and, ale_cs;
  logic [15:0] ale_port, ale_ded;
  logic [7:0] ale_seg;
  assign pins = {port_oe[1] ? port_out[15:8] : mdl[15:8], port_oe[0] ? port_out[7:0] : mdl[7:0]};
  assign grant_w = grant_oe ? grant_n_out : grant_drv;
  ebu_core i_dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_en), .req_in(req_in),
    .we_in(we_in), .addr_in(addr_in), .wdata_in(wdata_in), .ack_out(ack_out),
    .rdata_out(rdata_out), .busy_out(busy_out), .single_chip_in(single_chip_in),
    .addr_space_in(addr_space_in), .select_timing_config_bit_in(select_timing_config_bit),
    .arbitration_enable_bit_in(arb_en), .arbitration_pin_direction_bit_in(arb_dir),
    .window_address_select_reg_in(wasr), .window_bus_config_reg_in(wbcr),
    .default_bus_config_reg_in(dbcr), .shared_bus_port_in(pins),
    .shared_bus_port_out(port_out), .shared_bus_port_oe_out(port_oe),
    .dedicated_address_port_out(ded_out), .seg_addr_out(seg_out), .ale_out(ale_out),
    .rd_n_out(rd_n_out), .wr_n_out(wr_n_out), .cs_n_out(cs_n_out),
    .ctrl_oe_out(ctrl_oe_out), .ready_in(ready_w), .hold_n_in(hold_n_in),
    .bus_release_grant_n_in(grant_w), .bus_release_grant_n_out(grant_n_out),
    .bus_release_grant_oe_out(grant_oe), .bus_want_back_request_n_out(bus_want_back_request_n),
    .bus_want_back_request_oe_out(bus_want_back_request_oe)
  );
  ebu_mem_model i_mem (
    .sys_clk_in(sys_clk_in), .ale_in(ale_out), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out),
    .bus_drive_in(port_out), .bus_oe_in(port_oe), .addr_in(ded_out),
    .rdy_pol_in(rdy_pol), .rdy_delay_in(rdy_dly), .bus_pins_out(mdl), .ready_out(ready_w)
  );
  always #2.5 sys_clk_in = ~sys_clk_in;
  function automatic logic [15:0] cfg(input logic [7:0] f, input logic [3:0] w);
    cfg = (16'(f) << BC_TRI) | {12'h000, w};
  endfunction : cfg
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // one whole access; records selects and pins seen in the first latch cycle
  task automatic acc(input logic we, input logic [23:0] a, input logic [15:0] wd);
    logic got;
    got = 1'b0;
    n = 0;
    cs_and = 5'h1f;
    req_in = 1'b1;
    we_in = we;
    addr_in = a;
    wdata_in = wd;
    do begin
      @(negedge sys_clk_in);
      n++;
      cs_and &= cs_n_out;
      if (ale_out === 1'b1 && !got) begin
        got = 1'b1;
        ale_cs = cs_n_out;
        ale_port = port_out;
        ale_ded = ded_out;
        ale_seg = seg_out;
      end
    end while (ack_out !== 1'b1 && n < 60);
    ack_busy = busy_out;
    `CHK(ack_out, 1'b1)
    req_in = 1'b0;
    @(negedge sys_clk_in);
  endtask : acc
  task automatic t_reset;
    `CHK({ale_out, rd_n_out, wr_n_out, ack_out, ctrl_oe_out, busy_out}, 6'b011010)
    `CHK(cs_n_out, CS_IDLE)
    `CHK({port_oe, grant_oe, bus_want_back_request_oe}, 4'h0)
    $display("test reset done");
  endtask : t_reset
  task automatic t_modes;
    logic [23:0] a;
    logic [15:0] d;
    for (int m = 0; m < 4; m++) begin
      dbcr = cfg((m[0] ? F_MUX : 8'h00) | (m[1] ? F_B8 : 8'h00), 4'h0);
      a = 24'h000040 + 24'(2 * m);
      d = 16'hc3a0 + 16'(m);
      acc(1'b1, a, d);
      acc(1'b0, a, 16'h0000);
      `CHK(rdata_out, m[1] ? {8'h00, d[7:0]} : d)
      `CHK(m[0] ? ale_port : ale_ded, a[15:0])
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_windows;
    dbcr = 16'h0000;
    wasr = {4{16'h0104}};
    for (int k = 4; k >= 0; k--) begin
      for (int j = 0; j < 4; j++) wbcr[j] = cfg(j < k ? F_EN : 8'h00, 4'h0);
      acc(1'b0, 24'h010100, 16'h0000);
      `CHK(cs_and, 5'h1f & ~(5'h01 << k))
    end
    for (int j = 0; j < 4; j++) wbcr[j] = cfg(F_EN, 4'h0);
    acc(1'b0, 24'h020100, 16'h0000);
    `CHK(cs_and, 5'h1e)
    wbcr = '0;
    $display("test windows done");
  endtask : t_windows
  task automatic t_space;
    logic [7:0] msk [4] = '{8'hff, 8'h0f, 8'h03, 8'h00};
    for (int s = 0; s < 4; s++) begin
      addr_space_in = 2'(s);
      acc(1'b0, 24'hab1234, 16'h0000);
      `CHK(ale_seg, 8'hab & msk[s])
    end
    addr_space_in = 2'h0;
    $display("test space done");
  endtask : t_space
  task automatic t_cstime;
    for (int t = 0; t < 2; t++) begin
      select_timing_config_bit = t[0];
      acc(1'b0, 24'h000040, 16'h0000);
      `CHK(ale_cs, t[0] ? 5'h1e : 5'h1f)
    end
    select_timing_config_bit = 1'b0;
    $display("test select timing done");
  endtask : t_cstime
  task automatic t_timing;
    logic [15:0] cw [8];
    int ex [8] = '{3, 1, 1, 2, 2, 0, 2, 0};
    int n0;
    cw = '{cfg(8'h00, 4'h3), cfg(F_ALE, 4'h0), cfg(F_RWD, 4'h0), cfg(F_RE | F_POL, 4'h0),
           cfg(F_RE, 4'h0), cfg(8'h00, 4'h0), cfg(8'h00, 4'h2), cfg(F_TRI, 4'h0)};
    dbcr = 16'h0000;
    acc(1'b0, 24'h000040, 16'h0000);
    n0 = n;
    for (int i = 0; i < 8; i++) begin
      rdy_pol = (i != 4);
      rdy_dly = (i == 5) ? 4'hf : (i > 2 ? 4'h2 : 4'h0);
      dbcr = cw[i];
      acc(1'b0, 24'h000040, 16'h0000);
      `CHK(n, n0 + ex[i])
      `CHK(ack_busy, i == 7)
    end
    dbcr = 16'h0000;
    $display("test timing done");
  endtask : t_timing
  // clock enable dropped in the latch cycle must freeze the access there
  task automatic t_freeze;
    req_in = 1'b1;
    we_in = 1'b0;
    addr_in = 24'h000040;
    @(negedge sys_clk_in);
    ce_en = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    `CHK({ale_out, busy_out, cs_n_out}, 7'h7f)
    ce_en = 1'b1;
    acc(1'b0, 24'h000040, 16'h0000);
    `CHK(n, 2)
    $display("test freeze done");
  endtask : t_freeze
  task automatic t_single;
    single_chip_in = 1'b1;
    req_in = 1'b1;
    repeat (8) begin
      @(negedge sys_clk_in);
      `CHK({ack_out, cs_n_out}, 6'h1f)
    end
    req_in = 1'b0;
    single_chip_in = 1'b0;
    @(negedge sys_clk_in);
    $display("test single chip done");
  endtask : t_single
  task automatic t_hold;
    hold_n_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    `CHK(ctrl_oe_out, 1'b1)
    arb_en = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    `CHK({ctrl_oe_out, grant_n_out, grant_oe, port_oe}, 5'b00100)
    req_in = 1'b1;
    we_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    `CHK({ack_out, bus_want_back_request_n, bus_want_back_request_oe}, 3'b001)
    hold_n_in = 1'b1;
    acc(1'b0, 24'h000040, 16'h0000);
    arb_dir = 1'b1;
    @(negedge sys_clk_in);
    `CHK(grant_oe, 1'b0)
    grant_drv = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    `CHK(ctrl_oe_out, 1'b0)
    grant_drv = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    `CHK(ctrl_oe_out, 1'b1)
    arb_en = 1'b0;
    arb_dir = 1'b0;
    @(negedge sys_clk_in);
    $display("test hold done");
  endtask : t_hold
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(negedge sys_clk_in);
    rst_in = 1'b0;
    t_reset();
    t_modes();
    t_windows();
    t_space();
    t_cstime();
    t_timing();
    t_freeze();
    t_single();
    t_hold();
    wrap_up();
  end
endmodule : ebu_core_tb
`default_nettype wire

// ==== verification/ebu_mem_model.sv ====
// external memory on the far side of the bus unit: latches the address, stores
// writes and answers reads, with a ready line of programmable polarity and delay
// assumes the bench resolves the shared pins from both sides' enables
`timescale 1ns/1ps
`default_nettype none
module ebu_mem_model (
  input wire logic sys_clk_in,
  input wire logic ale_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic [15:0] bus_drive_in,
  input wire logic [1:0] bus_oe_in,
  input wire logic [15:0] addr_in,
  input wire logic rdy_pol_in,
  input wire logic [3:0] rdy_delay_in,
  output logic [15:0] bus_pins_out,
  output logic ready_out
);
  logic [15:0] mem [0:255];
  logic [15:0] adr_reg = 16'h0000;
  logic [15:0] last_reg = 16'h0000;
  logic [3:0] cnt_reg = 4'h0;
  wire logic strobe = !rd_n_in || !wr_n_in;
  always_ff @(posedge sys_clk_in) begin
    if (ale_in) begin
      adr_reg <= (bus_oe_in != 2'h0) ? bus_drive_in : addr_in;
    end
    if (!wr_n_in) begin
      mem[adr_reg[8:1]] <= bus_drive_in;
    end
    if (!strobe) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg != 4'hf) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
    last_reg <= bus_pins_out;
  end
  // released lines toggle so a stale value can never pass as read data
  assign bus_pins_out = !rd_n_in ? mem[adr_reg[8:1]] : ~last_reg;
  // each strobe is ended by the active level once the delay has run out
  assign ready_out = (strobe && cnt_reg >= rdy_delay_in) ? rdy_pol_in : !rdy_pol_in;
endmodule : ebu_mem_model
`default_nettype wire
